/* design/scs_ctrl.sv */
// scs_ctrl.sv: run-time system clock switch controller with AXI4-Lite registers
// assumes: all inputs synchronous to SYS_CLK; the new clock is seen as a one-cycle tick per edge
// What this block does
// R01: software picks any of six sources, locked
// R02: primary submode comes from configuration only
// R03: switching enabled only when config bit is zero
// R04: disabled: new field ignored, status shows initial
// R05: disabled: request bit has no effect, reads zero
// R06: software unlocks before each protected byte write
// R07: redundant request clears request bit, aborts
// R08: valid switch clears lock and fail flags
// R09: start new oscillator, wait startup timer if crystal
// R10: multiplier source waits for lock reading one
// R11: wait ten new clock cycles then switch
// R12: done: clear request, copy new to current
// R13: turn off old source with stated exceptions; the code keeps the low-power RC on after every switch
// R14: processor keeps running during the switch
// R15: software routes multiplier to multiplier via fast RC
// R16: key pair unlocks one protected byte write
`include "scs_map.svh"
`timescale 1ns/10ps
`default_nettype none

module scs_ctrl (
	input  wire logic                      SYS_CLK,
	input  wire logic                      NRST,
	// axi4-lite slave
	input  wire logic [11:0]               S_AXI_AWADDR,
	input  wire logic                      S_AXI_AWVALID,
	output logic                           S_AXI_AWREADY,
	input  wire logic [31:0]               S_AXI_WDATA,
	input  wire logic [3:0]                S_AXI_WSTRB,
	input  wire logic                      S_AXI_WVALID,
	output logic                           S_AXI_WREADY,
	output logic [1:0]                     S_AXI_BRESP,
	output logic                           S_AXI_BVALID,
	input  wire logic                      S_AXI_BREADY,
	input  wire logic [11:0]               S_AXI_ARADDR,
	input  wire logic                      S_AXI_ARVALID,
	output logic                           S_AXI_ARREADY,
	output logic [31:0]                    S_AXI_RDATA,
	output logic [1:0]                     S_AXI_RRESP,
	output logic                           S_AXI_RVALID,
	input  wire logic                      S_AXI_RREADY,
	// configuration settings
	input  wire logic                      SWITCH_MONITOR_CONFIG,
	input  wire logic [2:0]                INITIAL_SOURCE_CONFIG,
	input  wire logic [1:0]                PRIMARY_SUBMODE_CONFIG,
	input  wire logic                      WATCHDOG_TIMER_EN,
	input  wire logic                      SECONDARY_KEEP_ON,
	input  wire logic                      CLOCK_FAIL_EVENT,
	// oscillator side
	input  wire scs_pkg::scs_osc_stat_type OSC_STAT,
	output scs_pkg::scs_osc_en_type        OSC_EN,
	output logic [1:0]                     PRIMARY_SUBMODE,
	output logic [2:0]                     CLOCK_SELECT,
	output logic                           IRQ
);

	// ======================================================================
	// state machine of the switch sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_START,
		ST_LOCK,
		ST_SETTLE,
		ST_SWITCH
	} scs_state_type;

	scs_state_type   state_ff;                 // sequence state
	scs_state_type   nxt_state;                // next sequence state
	logic [2:0]      new_ff;                   // requested source
	logic [2:0]      cur_ff;                   // source in use
	logic            req_ff;                   // switch request bit
	logic            lock_ff;                  // multiplier lock status
	logic            cfail_ff;                 // clock fail status
	logic [3:0]      settle_ff;                // new clock edges counted
	logic [1:0]      unl_hi_ff;                // high byte unlock progress
	logic [1:0]      unl_lo_ff;                // low byte unlock progress
	logic [`SCS_EV_W-1:0] stat_ff;             // sticky events
	logic [`SCS_EV_W-1:0] mask_ff;             // event mask
	scs_pkg::scs_osc_en_type osc_en_ff;        // oscillator enables
	logic [1:0]      submode_ff;               // primary submode caught after reset
	logic            started_ff;               // strap capture done

	// axi holding registers
	logic            aw_ff;                    // write address held
	logic            w_ff;                     // write data held
	logic [11:0]     awaddr_ff;                // held write address
	logic [31:0]     wdata_ff;                 // held write data
	logic [3:0]      wstrb_ff;                 // held strobes
	logic            bvalid_ff;                // write response pending
	logic            rvalid_ff;                // read data pending
	logic [31:0]     rdata_ff;                 // read data
	logic [1:0]      bresp_ff;                 // write response code
	logic [1:0]      rresp_ff;                 // read response code

	logic            sw_en;                    // switching enabled
	logic            wr_go;                    // write performed this cycle
	logic            rd_go;                    // read performed this cycle
	logic            wr_ctrl;                  // write to control register
	logic            wr_key;                   // write to key register
	logic [`SCS_EV_W-1:0] ev;                  // events this cycle

	// ======================================================================
	// helpers
	// oscillator that a source code runs from
	function automatic scs_pkg::scs_osc_en_type osc_of(input logic [2:0] src);
		scs_pkg::scs_osc_en_type o;
		o = '0;
		case (src)
			3'h2, 3'h3: o.primary_osc      = 1'b1;
			3'h4:       o.secondary_osc    = 1'b1;
			3'h5:       o.low_power_rc_osc = 1'b1;
			default:    o.fast_rc_osc      = 1'b1;
		endcase
		return o;
	endfunction : osc_of

	// source routed through the frequency multiplier
	function automatic logic uses_mul(input logic [2:0] src);
		return (src == 3'h1) || (src == 3'h3);
	endfunction : uses_mul

	// crystal sources need the startup timer; external clock input does not
	function automatic logic is_crystal(input logic [2:0] src, input logic [1:0] sub);
		return (src == 3'h4) || (((src == 3'h2) || (src == 3'h3)) && (sub != 2'h0));
	endfunction : is_crystal

	// defined register offset
	function automatic logic known(input logic [11:0] a);
		return (a == `SCS_OFF_CTRL) || (a == `SCS_OFF_KEY) ||
			(a == `SCS_OFF_IRQ_STAT) || (a == `SCS_OFF_IRQ_MASK);
	endfunction : known

	// ======================================================================
	// configuration gate, active when programmed to zero
	assign sw_en = ~SWITCH_MONITOR_CONFIG;     // R03

	// ======================================================================
	// axi write channel: address and data in either order
	assign S_AXI_AWREADY = ~aw_ff & ~bvalid_ff;
	assign S_AXI_WREADY  = ~w_ff & ~bvalid_ff;
	assign wr_go   = aw_ff & w_ff & ~bvalid_ff;
	assign wr_ctrl = wr_go && (awaddr_ff == `SCS_OFF_CTRL);
	assign wr_key  = wr_go && (awaddr_ff == `SCS_OFF_KEY) && wstrb_ff[0];

	// capture address and data, release after response
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= {S_AXI_AWADDR[11:2], 2'b00};
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_ff     <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb_ff <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
		end
	end

	// write response, slverr for unmapped offsets
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'b00;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= known(awaddr_ff) ? 2'b00 : 2'b10;
		end else if (S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP  = bresp_ff;

	// ======================================================================
	// axi read channel: one cycle to data
	assign S_AXI_ARREADY = ~rvalid_ff;
	assign rd_go = S_AXI_ARVALID & ~rvalid_ff;

	// read mux; the control word mirrors the documented layout
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'b00;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= known({S_AXI_ARADDR[11:2], 2'b00}) ? 2'b00 : 2'b10;
			case ({S_AXI_ARADDR[11:2], 2'b00})
				`SCS_OFF_CTRL: begin
					rdata_ff <= 32'h0000_0000;
					rdata_ff[`SCS_CUR_LSB +: 3] <= cur_ff;
					rdata_ff[`SCS_NEW_LSB +: 3] <= new_ff;
					rdata_ff[`SCS_BIT_LOCK]     <= lock_ff;
					rdata_ff[`SCS_BIT_CFAIL]    <= cfail_ff;
					rdata_ff[`SCS_BIT_REQ]      <= req_ff & sw_en;   // R05
				end
				`SCS_OFF_IRQ_STAT: rdata_ff <= {29'h0, stat_ff};
				`SCS_OFF_IRQ_MASK: rdata_ff <= {29'h0, mask_ff};
				default:           rdata_ff <= 32'h0000_0000;      // keys read as zero
			endcase
		end else if (S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA  = rdata_ff;
	assign S_AXI_RRESP  = rresp_ff;

	// ======================================================================
	// unlock: a matching key pair opens one protected byte write
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			unl_hi_ff <= 2'h0;
			unl_lo_ff <= 2'h0;
		end else if (wr_key) begin
			// any key write restarts the other sequence; mismatch relocks
			unl_lo_ff <= 2'h0;
			unl_hi_ff <= 2'h0;
			if (wdata_ff[7:0] == `SCS_KEY_HI_A)
				unl_hi_ff <= 2'h1;                                    // R16
			else if (wdata_ff[7:0] == `SCS_KEY_HI_B && unl_hi_ff == 2'h1)
				unl_hi_ff <= 2'h2;                                    // R16
			if (wdata_ff[7:0] == `SCS_KEY_LO_A)
				unl_lo_ff <= 2'h1;                                    // R16
			else if (wdata_ff[7:0] == `SCS_KEY_LO_B && unl_lo_ff == 2'h1)
				unl_lo_ff <= 2'h2;                                    // R16
		end else if (wr_go) begin
			// any other write consumes or cancels an open unlock
			unl_hi_ff <= 2'h0;                                        // R16
			unl_lo_ff <= 2'h0;                                        // R16
		end else begin
			if (unl_hi_ff == 2'h1) unl_hi_ff <= unl_hi_ff;
			if (unl_lo_ff == 2'h1) unl_lo_ff <= unl_lo_ff;
		end
	end

	// ======================================================================
	// strap capture after reset release; submode never changes by software
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			started_ff <= 1'b0;
			submode_ff <= 2'h0;
		end else if (!started_ff) begin
			started_ff <= 1'b1;
			submode_ff <= PRIMARY_SUBMODE_CONFIG;                    // R02
		end
	end

	assign PRIMARY_SUBMODE = submode_ff;                             // R02

	// ======================================================================
	// new source field, written through the unlocked high byte
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			new_ff <= 3'h0;
		end else if (!started_ff) begin
			new_ff <= INITIAL_SOURCE_CONFIG;
		end else if (wr_ctrl && wstrb_ff[1] && unl_hi_ff == 2'h2 && state_ff == ST_IDLE) begin
			new_ff <= wdata_ff[`SCS_NEW_LSB +: 3];                   // R01
		end
	end

	// ======================================================================
	// switch request bit; set by unlocked low byte, cleared by hardware
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			req_ff <= 1'b0;
		end else if (!sw_en) begin
			req_ff <= 1'b0;                                           // R05
		end else if (state_ff == ST_CHECK && cur_ff == new_ff) begin
			req_ff <= 1'b0;                                           // R07
		end else if (state_ff == ST_SWITCH) begin
			req_ff <= 1'b0;                                           // R12
		end else if (wr_ctrl && wstrb_ff[0] && unl_lo_ff == 2'h2 && wdata_ff[`SCS_BIT_REQ]) begin
			req_ff <= 1'b1;                                           // R01
		end
	end

	// ======================================================================
	// switch sequence next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:   if (req_ff && sw_en) nxt_state = ST_CHECK;
			ST_CHECK:  nxt_state = (cur_ff == new_ff) ? ST_IDLE : ST_START;       // R07
			ST_START:  if (!is_crystal(new_ff, submode_ff) || OSC_STAT.startup_timer_done)
				nxt_state = ST_LOCK;                                              // R09
			ST_LOCK:   if (!uses_mul(new_ff) || lock_ff)
				nxt_state = ST_SETTLE;                                            // R10
			ST_SETTLE: if (settle_ff == `SCS_SETTLE_CYC) nxt_state = ST_SWITCH;   // R11
			ST_SWITCH: nxt_state = ST_IDLE;
			default:   nxt_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) state_ff <= ST_IDLE;
		else       state_ff <= nxt_state;
	end

	// ten ticks of the new clock before switching
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			settle_ff <= 4'h0;
		end else if (state_ff != ST_SETTLE) begin
			settle_ff <= 4'h0;
		end else if (OSC_STAT.new_clock_tick && settle_ff != `SCS_SETTLE_CYC) begin
			settle_ff <= settle_ff + 4'h1;                            // R11
		end
	end

	// ======================================================================
	// lock and fail status; fail event wins over the clear
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			lock_ff  <= 1'b0;
			cfail_ff <= 1'b0;
		end else begin
			if (state_ff == ST_CHECK && cur_ff != new_ff)
				lock_ff <= 1'b0;                                      // R08
			else
				lock_ff <= OSC_STAT.multiplier_lock;                  // R10
			if (CLOCK_FAIL_EVENT && sw_en)
				cfail_ff <= 1'b1;
			else if (state_ff == ST_CHECK && cur_ff != new_ff)
				cfail_ff <= 1'b0;                                     // R08
		end
	end

	// ======================================================================
	// current source; follows initial config while switching is off
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			cur_ff <= 3'h0;
		end else if (!started_ff || !sw_en) begin
			cur_ff <= INITIAL_SOURCE_CONFIG;                          // R04
		end else if (state_ff == ST_SWITCH) begin
			cur_ff <= new_ff;                                         // R12
		end
	end

	assign CLOCK_SELECT = cur_ff;                                     // R04

	// ======================================================================
	// oscillator enables: new one on at start, old one off after switch unless it is the low-power RC or held on
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			osc_en_ff <= '0;
		end else if (!started_ff || !sw_en) begin
			osc_en_ff <= osc_of(INITIAL_SOURCE_CONFIG) |
				{1'b0, SECONDARY_KEEP_ON, 1'b0, WATCHDOG_TIMER_EN};
		end else if (state_ff == ST_START) begin
			osc_en_ff <= osc_en_ff | osc_of(new_ff);                  // R09
		end else if (state_ff == ST_SWITCH) begin
			// old source drops unless an exception holds it; low-power RC is held after every switch
			osc_en_ff <= osc_of(new_ff) |
				{1'b0, SECONDARY_KEEP_ON, 1'b0, WATCHDOG_TIMER_EN | sw_en};  // R13
		end else begin
			osc_en_ff.secondary_osc <= osc_en_ff.secondary_osc | SECONDARY_KEEP_ON;
		end
	end

	assign OSC_EN = osc_en_ff;

	// ======================================================================
	// interrupt events: done, redundant abort, clock fail
	assign ev = {CLOCK_FAIL_EVENT & sw_en,
		state_ff == ST_CHECK && cur_ff == new_ff,
		state_ff == ST_SWITCH};

	// sticky status, write one to clear, set wins
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			stat_ff <= '0;
			mask_ff <= '0;
		end else begin
			if (wr_go && awaddr_ff == `SCS_OFF_IRQ_STAT && wstrb_ff[0])
				stat_ff <= (stat_ff & ~wdata_ff[`SCS_EV_W-1:0]) | ev;
			else
				stat_ff <= stat_ff | ev;
			if (wr_go && awaddr_ff == `SCS_OFF_IRQ_MASK && wstrb_ff[0])
				mask_ff <= wdata_ff[`SCS_EV_W-1:0];
		end
	end

	assign IRQ = |(stat_ff & mask_ff);

endmodule : scs_ctrl

`default_nettype wire

/* design/scs_map.svh */
// scs_map.svh: offsets, field positions, unlock keys, event bits and timing counts of the clock switch controller
// assumes: included by the package user files; AXI4-Lite byte addresses, one 32-bit word per register
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// ==========================================================================
// register byte offsets
`define SCS_OFF_CTRL      12'h000
`define SCS_OFF_KEY       12'h004
`define SCS_OFF_IRQ_STAT  12'h008
`define SCS_OFF_IRQ_MASK  12'h00C

// ==========================================================================
// control register fields
`define SCS_BIT_REQ       0
`define SCS_BIT_CFAIL     3
`define SCS_BIT_LOCK      5
`define SCS_NEW_LSB       8
`define SCS_CUR_LSB       12

// ==========================================================================
// unlock keys, arbitrary values
`define SCS_KEY_HI_A      8'h46
`define SCS_KEY_HI_B      8'h57
`define SCS_KEY_LO_A      8'h9A
`define SCS_KEY_LO_B      8'hB5

// ==========================================================================
// event bits in status and mask
`define SCS_EV_DONE       0
`define SCS_EV_ABORT      1
`define SCS_EV_FAIL       2
`define SCS_EV_W          3

// ==========================================================================
// timing: settle count in cycles of the new clock
`define SCS_SETTLE_CYC    4'hA

`endif

/* design/scs_pkg.sv */
// scs_pkg.sv: types of the clock switch controller
// assumes: nothing beyond a SystemVerilog compiler
package scs_pkg;
	// ======================================================================
	// clock source codes, three bits wide
	typedef enum logic [2:0] {
		SRC_FAST_RC     = 3'h0,
		SRC_FAST_RC_MUL = 3'h1,
		SRC_PRIMARY     = 3'h2,
		SRC_PRIMARY_MUL = 3'h3,
		SRC_SECONDARY   = 3'h4,
		SRC_LOW_POWER   = 3'h5
	} scs_src_type;

	// ======================================================================
	// separate enables of the four oscillators, several may be on at once
	typedef struct packed {
		logic primary_osc;
		logic secondary_osc;
		logic fast_rc_osc;
		logic low_power_rc_osc;
	} scs_osc_en_type;

	// ======================================================================
	// readiness reports from oscillators and multiplier
	typedef struct packed {
		logic startup_timer_done;
		logic multiplier_lock;
		logic new_clock_tick;
	} scs_osc_stat_type;
endpackage : scs_pkg

/* verif/scs_ctrl_monitor.sv */
// scs_ctrl_monitor.sv: port checker of the clock switch controller
// assumes: one clock, NRST async active low, bench answers at once
`timescale 1ns/10ps
`default_nettype none
module scs_ctrl_monitor (
	input  wire logic                      SYS_CLK,
	input  wire logic                      NRST,
	input  wire logic                      S_AXI_AWVALID,
	input  wire logic                      S_AXI_AWREADY,
	input  wire logic                      S_AXI_WVALID,
	input  wire logic                      S_AXI_WREADY,
	input  wire logic [1:0]                S_AXI_BRESP,
	input  wire logic                      S_AXI_BVALID,
	input  wire logic                      S_AXI_ARVALID,
	input  wire logic                      S_AXI_ARREADY,
	input  wire logic                      S_AXI_RVALID,
	input  wire logic                      SWITCH_MONITOR_CONFIG,
	input  wire logic [2:0]                INITIAL_SOURCE_CONFIG,
	input  wire logic                      SECONDARY_KEEP_ON,
	input  wire scs_pkg::scs_osc_stat_type OSC_STAT,
	input  wire scs_pkg::scs_osc_en_type   OSC_EN,
	input  wire logic [1:0]                PRIMARY_SUBMODE,
	input  wire logic [2:0]                CLOCK_SELECT
);
	// ==========================================================
	// helpers
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	logic [7:0] tk_ff; // ticks since last write
	// no writes during a switch, so a write marks its start
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) tk_ff <= 8'h00;
		else if (S_AXI_AWVALID && S_AXI_AWREADY) tk_ff <= 8'h00;
		else if (OSC_STAT.new_clock_tick && tk_ff != 8'hFF) tk_ff <= tk_ff + 8'h01;
	end
	// enable bit a source needs
	function automatic logic [3:0] osc_of(input logic [2:0] s);
		case (s)
			3'h0, 3'h1: osc_of = 4'h2;
			3'h2, 3'h3: osc_of = 4'h8;
			3'h4: osc_of = 4'h4;
			default: osc_of = 4'h1;
		endcase
	endfunction : osc_of
	logic [2:0] tk_sel_ff; // last current source
	logic sel_chg; // current source moved
	assign sel_chg = (CLOCK_SELECT != tk_sel_ff);
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) tk_sel_ff <= 3'h0;
		else tk_sel_ff <= CLOCK_SELECT;
	end
	// ==========================================================
	// assertions
	AST_BWAIT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("late write response");
	AST_RWAIT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("late read data");
	AST_SUBMODE: assert property ($past(NRST, 2) |-> $stable(PRIMARY_SUBMODE))
		else $error("submode moved");
	AST_DISSEL: assert property ($past(NRST) && SWITCH_MONITOR_CONFIG |-> CLOCK_SELECT == INITIAL_SOURCE_CONFIG)
		else $error("disabled source wrong");
	AST_SELCHG: assert property ($past(NRST) && sel_chg |-> !SWITCH_MONITOR_CONFIG)
		else $error("switch while disabled");
	AST_NEWON: assert property ($past(NRST) && sel_chg |-> (4'(OSC_EN) & osc_of(CLOCK_SELECT)) != 4'h0)
		else $error("new source off");
	AST_OLDOFF: assert property ($past(NRST) && sel_chg |-> (4'(OSC_EN) & osc_of(tk_sel_ff)
		& ~osc_of(CLOCK_SELECT) & {1'b1, !SECONDARY_KEEP_ON, 2'b10}) == 4'h0) else $error("old source left on");
	AST_LOCKWAIT: assert property ($past(NRST) && sel_chg && !CLOCK_SELECT[2] && CLOCK_SELECT[0]
		|-> $past(OSC_STAT.multiplier_lock)) else $error("switch before lock");
	AST_SETTLE: assert property ($past(NRST) && sel_chg |-> tk_ff >= 8'h0A)
		else $error("switch before ten ticks");
	// ==========================================================
	// covers
	COV_SWITCH: cover property ($past(NRST) && sel_chg);
	COV_SLVERR: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
	COV_MUL: cover property (CLOCK_SELECT == 3'h3 && OSC_STAT.multiplier_lock);
endmodule : scs_ctrl_monitor
bind scs_ctrl scs_ctrl_monitor scs_ctrl_monitor_inst (.*);
`default_nettype wire

/* verif/scs_osc_model.sv */
// scs_osc_model.sv: oscillators and multiplier beside the controller
// assumes: enables synchronous to clk; delays in clk cycles
`timescale 1ns/10ps
`default_nettype none
module scs_osc_model #(
	parameter int DLY = 20, // start-up cycles
	parameter int DIV = 4   // clk cycles per tick
) (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire scs_pkg::scs_osc_en_type   osc_en,
	output scs_pkg::scs_osc_stat_type      osc_stat
);
	logic [7:0]               up_ff;  // cycles since enable change
	logic [7:0]               div_ff; // tick divider
	scs_pkg::scs_osc_en_type  en_ff;  // last enables
	// ==========================================================
	// start-up and lock: any enable change restarts the wait
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_ff <= 8'h00;
			en_ff <= '0;
		end else begin
			en_ff <= osc_en;
			if (osc_en != en_ff) up_ff <= 8'h00;
			else if (up_ff != 8'hFF) up_ff <= up_ff + 8'h01;
		end
	end
	// free-running divider; no tick while every oscillator is off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) div_ff <= 8'h00;
		else div_ff <= (int'(div_ff) == DIV - 1) ? 8'h00 : div_ff + 8'h01;
	end
	assign osc_stat.startup_timer_done = int'(up_ff) >= DLY;
	assign osc_stat.multiplier_lock    = int'(up_ff) >= 2 * DLY;
	assign osc_stat.new_clock_tick     = div_ff == 8'h00 && |osc_en;
endmodule : scs_osc_model
`default_nettype wire

/* verif/tb.sv */
// tb.sv: register tests of the clock switch controller
// assumes: scs_map.svh on the include path, monitor bound
`include "scs_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk, nrst, awv, wv, bready, arv, rready, cfg_dis, fail_ev; // bench-driven
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rd_d, rdata;
	logic [3:0]  wstrb;
	logic [2:0]  msk, sel;
	logic [1:0]  rsp, bresp, rresp;
	logic        awrdy, wrdy, bvalid, arrdy, rvalid, irq; // design outputs
	scs_pkg::scs_osc_stat_type stat;
	scs_pkg::scs_osc_en_type   en;
	int          err_count, n_checks, cyc;
	scs_ctrl scs_ctrl_inst (.SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SWITCH_MONITOR_CONFIG(cfg_dis),
		.INITIAL_SOURCE_CONFIG(3'h0), .PRIMARY_SUBMODE_CONFIG(2'h1), .WATCHDOG_TIMER_EN(cfg_dis),
		.SECONDARY_KEEP_ON(1'b0), .CLOCK_FAIL_EVENT(fail_ev), .OSC_STAT(stat), .OSC_EN(en),
		.PRIMARY_SUBMODE(), .CLOCK_SELECT(sel), .IRQ(irq));
	scs_osc_model #(.DLY(20), .DIV(4)) scs_osc_model_inst (.clk(clk), .nrst(nrst), .osc_en(en), .osc_stat(stat));
	// ==========================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			summarize();
		end
	end
	// ==========================================================
	// bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// address and data together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		{awaddr, wdata, wstrb, awv, wv, bready} <= {a, d, s, 3'b111};
		do begin
			@(posedge clk);
			if (awv && awrdy) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		{araddr, arv, rready} <= {a, 2'b11};
		do begin
			@(posedge clk);
			if (arv && arrdy) arv <= 1'b0;
		end while (!rvalid);
		{rsp, rd_d} = {rresp, rdata};
		rready <= 1'b0;
	endtask : rd
	task automatic rst();
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : rst
	// one switch: unlock, new, unlock, request, poll, events
	task automatic sw(input logic [2:0] src, input logic bad, input logic [2:0] cur, input logic [2:0] ev);
		int n;
		wr(`SCS_OFF_KEY, {24'h0, `SCS_KEY_HI_A}, 4'h1);
		wr(`SCS_OFF_KEY, {24'h0, bad ? 8'h00 : `SCS_KEY_HI_B}, 4'h1);
		wr(`SCS_OFF_CTRL, {21'h0, src, 8'h00}, 4'h2);
		wr(`SCS_OFF_KEY, {24'h0, `SCS_KEY_LO_A}, 4'h1);
		wr(`SCS_OFF_KEY, {24'h0, `SCS_KEY_LO_B}, 4'h1);
		wr(`SCS_OFF_CTRL, 32'h1, 4'h1);
		n = 0;
		do begin
			rd(`SCS_OFF_CTRL);
			n++;
		end while (rd_d[0] === 1'b1 && n < 200);
		chk(rd_d & 32'h7009, {17'h0, cur, 12'h0});
		chk({29'h0, sel}, {29'h0, cur});
		rd(`SCS_OFF_IRQ_STAT);
		chk(rd_d, {29'h0, ev});
		chk({31'h0, irq}, {31'h0, |(ev & msk)});
		wr(`SCS_OFF_IRQ_STAT, {29'h0, ev}, 4'h1);
		chk({31'h0, irq}, 32'h0);
	endtask : sw
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// ==========================================================
	// main sequence
	logic [2:0] tbl [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h0};
	initial begin
		{awv, wv, bready, arv, rready, fail_ev, nrst} = 7'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{cfg_dis, msk} = 4'b1000;
		rst();
		sw(3'h2, 1'b0, 3'h0, 3'h0);
		cfg_dis <= 1'b0;
		rst();
		rd(12'h010);
		chk({30'h0, rsp}, 32'h2);
		chk(rd_d, 32'h0);
		wr(12'h010, 32'h0, 4'hF);
		chk({30'h0, rsp}, 32'h2);
		wr(`SCS_OFF_IRQ_MASK, 32'h0, 4'h1);
		foreach (tbl[i]) begin
			if (i == 1) begin
				wr(`SCS_OFF_IRQ_MASK, 32'h7, 4'h1);
				msk = 3'h7;
			end
			sw(tbl[i], 1'b0, tbl[i], 3'h1);
		end
		sw(3'h0, 1'b0, 3'h0, 3'h2);
		sw(3'h4, 1'b1, 3'h0, 3'h2);
		@(posedge clk) fail_ev <= 1'b1;
		@(posedge clk) fail_ev <= 1'b0;
		rd(`SCS_OFF_CTRL);
		chk({31'h0, rd_d[3]}, 32'h1);
		rd(`SCS_OFF_IRQ_STAT);
		chk(rd_d, 32'h4);
		wr(`SCS_OFF_IRQ_STAT, 32'h4, 4'h1);
		sw(3'h2, 1'b0, 3'h2, 3'h1);
		summarize();
	end
endmodule : tb
`default_nettype wire
